/* File: lcfsc_top.sv */
/*
 * Loop delay, fast-move restart and magnetoresistive_feedback
 * calibration block: per-axis controller delay, fast-move enable and
 * restart counter, sensor offsets, peak limits and live sample readout,
 * all behind a classic Wishbone slave.
 * Assumes position errors, controller requests and sensor samples come
 * from logic on CLK; one bus master; 32-bit word accesses.
 */
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - each of four axes holds its own controller delay of 0 to 100 ms.
// - a delay of zero lets the controller act without waiting.
// - one word returns all four delays, one word per axis returns one.
// - a single fast-move flag is written and read back as 0 or 1.
// - with fast-move on, an error beyond capture range starts a vector.
// - each vector restart adds one to a readable 0 to 255 counter.
// - writing zero to the counter clears it, later restarts count anew.
// - each axis stores signed sine and cosine offsets within 2048.
// - sequential offset writes fill X sin, X cos, Y sin and onward.
// - offsets read back sine first, then cosine, for every axis.
// - each axis stores four signed peaks in a fixed reported order.
// - an empty peak command or a seventeenth value gives error code 2.
// - live values read only per axis; other forms give error code 2.
// - a live query yields ten consecutive sine/cosine pairs.
module lcfsc_top #(
   parameter int MS_CYCLES = lcfsc_pkg::MS_CYCLES
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [11:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic [3:0][15:0] POS_ERR,
   input wire logic [3:0] CTRL_REQ,
   output logic [3:0] CTRL_GO,
   output logic [3:0] VECTOR_START,
   input wire logic MR_VALID,
   input wire lcfsc_pkg::lcfsc_pair_s [3:0] MR_SAMPLE,
   output lcfsc_pkg::lcfsc_pair_s [3:0] MR_OFFSET,
   output logic [3:0][3:0][12:0] MR_PEAK,
   output logic IRQ
);
   localparam int NA = lcfsc_pkg::N_AXES;
   localparam int SW = lcfsc_pkg::STAT_W;
   localparam int PEAK_END_BIT_C = lcfsc_pkg::PEAK_END_BIT;
   localparam logic [7:0] PEAK_SLOTS_C = 8'(lcfsc_pkg::PEAK_SLOTS);

   // ==========================================================
   // helpers
   function automatic logic val_ok(input logic [31:0] d);
      logic signed [31:0] v;
      v = $signed(d);
      return (v >= -lcfsc_pkg::VAL_LIM) && (v <= lcfsc_pkg::VAL_LIM);
   endfunction

   function automatic logic [15:0] mag(input logic [15:0] e);
      return e[15] ? 16'(-e) : e;
   endfunction

   function automatic logic [2:0] ones(input logic [3:0] v);
      return 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
   endfunction

   // ==========================================================
   // state
   logic fm_en;
   logic [7:0] fm_cnt;
   logic [15:0] cap_range;
   logic [6:0] delay [NA];
   logic [12:0] ofs [lcfsc_pkg::OFS_SLOTS];
   logic [12:0] peak [lcfsc_pkg::PEAK_SLOTS];
   logic [3:0] ofs_ptr;
   logic [4:0] peak_ptr;
   logic peak_seen;
   logic [SW-1:0] stat;
   logic [SW-1:0] mask;
   logic [7:0] err_code;
   logic [3:0] exceed_q;
   logic [6:0] rem [NA];
   lcfsc_pkg::lcfsc_dly_e dly_st [NA];
   int ms_div;
   logic ms_tick;

   // ==========================================================
   // bus decode
   logic req, wr, rd;
   logic [11:0] a;
   logic [31:0] d;
   logic hit_delay, hit_ofs, hit_peak, hit_live, live_ok;
   logic [1:0] d_ax;
   logic [2:0] o_slot;
   logic [3:0] p_slot;
   logic [11:0] p_off;
   logic rej, rej_syn;
   logic [31:0] next_rdata;
   logic live_rd;
   lcfsc_pkg::lcfsc_pair_s live_pair;
   logic [3:0] exceed, restart;
   logic [8:0] cnt_sum;

   // one access per request; partial byte writes are ignored
   assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign wr = req && WB_WE_I && (WB_SEL_I == 4'hf);
   assign rd = req && !WB_WE_I;
   assign a = WB_ADR_I;
   assign d = WB_DAT_I;
   assign p_off = a - lcfsc_pkg::A_PEAK_BASE;

   // window hits; misaligned addresses hit nothing
   always_comb begin
      hit_delay = (a[11:4] == lcfsc_pkg::A_DELAY_BASE[11:4]);
      hit_ofs = (a[11:5] == lcfsc_pkg::A_OFS_BASE[11:5]);
      hit_peak = (a >= lcfsc_pkg::A_PEAK_BASE) &&
                 (a < lcfsc_pkg::A_PEAK_END);
      hit_live = (a >= lcfsc_pkg::A_LIVE_BASE) &&
                 (a < lcfsc_pkg::A_LIVE_END);
      if (a[1:0] != 2'b00) begin
         hit_delay = 1'b0;
         hit_ofs = 1'b0;
         hit_peak = 1'b0;
         hit_live = 1'b0;
      end
      d_ax = a[3:2];
      o_slot = a[4:2];
      p_slot = p_off[5:2];
      live_ok = (a[5:2] < 4'(lcfsc_pkg::LIVE_DEPTH));
   end

   // ==========================================================
   // refused writes and queries
   always_comb begin
      rej = 1'b0;
      rej_syn = 1'b0;
      if (wr) begin
         if (a == lcfsc_pkg::A_CTRL && d > 32'h1) rej = 1'b1;
         if (hit_delay && d > 32'(lcfsc_pkg::DELAY_MAX)) rej = 1'b1;
         if (a == lcfsc_pkg::A_FMCNT && d != 32'h0) rej = 1'b1;
         if ((hit_ofs || hit_peak) && !val_ok(d)) rej = 1'b1;
         if (a == lcfsc_pkg::A_OFS_SEQ && !val_ok(d)) rej = 1'b1;
         if (a == lcfsc_pkg::A_PEAK_SEQ && !val_ok(d)) rej = 1'b1;
         if (a == lcfsc_pkg::A_OFS_PTR &&
             d >= 32'(lcfsc_pkg::OFS_SLOTS)) rej = 1'b1;
         if (a == lcfsc_pkg::A_PEAK_PTR && d[PEAK_END_BIT_C-1:0] >=
             PEAK_SLOTS_C) rej = 1'b1;
         // no slot left in the offset sequence
         if (a == lcfsc_pkg::A_OFS_SEQ &&
             ofs_ptr == 4'(lcfsc_pkg::OFS_SLOTS)) rej_syn = 1'b1;
         // past sixteen values, or a command with none
         if (a == lcfsc_pkg::A_PEAK_SEQ &&
             peak_ptr == 5'(lcfsc_pkg::PEAK_SLOTS)) rej_syn = 1'b1;
         if (a == lcfsc_pkg::A_PEAK_PTR &&
             d[lcfsc_pkg::PEAK_END_BIT] && !peak_seen) rej_syn = 1'b1;
         // live values take no write of any form
         if (hit_live || a == lcfsc_pkg::A_LIVE_ALL) rej_syn = 1'b1;
      end
      if (rd && a == lcfsc_pkg::A_LIVE_ALL) rej_syn = 1'b1;
   end

   // ==========================================================
   // bus answer: one wait state, ack for exactly one cycle
   always_ff @(posedge CLK) begin
      if (RST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0;
      end else begin
         WB_ACK_O <= req;
         WB_DAT_O <= rd ? next_rdata : 32'h0;
      end
   end

   // read mux; unmapped words and write-only sequences read zero
   always_comb begin
      next_rdata = 32'h0;
      live_rd = 1'b0;
      case (a)
         lcfsc_pkg::A_CTRL: next_rdata[lcfsc_pkg::CTRL_FM_BIT] = fm_en;
         lcfsc_pkg::A_STAT: next_rdata[SW-1:0] = stat;
         lcfsc_pkg::A_MASK: next_rdata[SW-1:0] = mask;
         lcfsc_pkg::A_ERR: next_rdata[7:0] = err_code;
         // all delays in one word, X in the low byte
         lcfsc_pkg::A_DELAY_ALL: next_rdata = {1'b0, delay[3], 1'b0,
            delay[2], 1'b0, delay[1], 1'b0, delay[0]};
         lcfsc_pkg::A_FMCNT: next_rdata[7:0] = fm_cnt;
         lcfsc_pkg::A_RANGE: next_rdata[15:0] = cap_range;
         lcfsc_pkg::A_OFS_PTR: next_rdata[3:0] = ofs_ptr;
         lcfsc_pkg::A_PEAK_PTR: next_rdata[4:0] = peak_ptr;
         default: begin
            if (hit_delay) next_rdata[6:0] = delay[d_ax];
            // sine at even word, cosine at the odd one
            if (hit_ofs) next_rdata = 32'($signed(ofs[o_slot]));
            if (hit_peak) next_rdata = 32'($signed(peak[p_slot]));
            // pair k of ten, oldest first
            if (hit_live && live_ok) begin
               live_rd = rd;
               next_rdata[12:0] = live_pair.sin;
               next_rdata[lcfsc_pkg::LIVE_COS_LSB +: 13] = live_pair.cos;
            end
         end
      endcase
   end

   // ==========================================================
   // settings
   always_ff @(posedge CLK) begin
      if (RST) begin
         fm_en <= 1'b0;
         cap_range <= lcfsc_pkg::RANGE_RST;
         mask <= '0;
         for (int i = 0; i < NA; i++) delay[i] <= lcfsc_pkg::DELAY_RST;
      end else if (wr && !rej && !rej_syn) begin
         if (a == lcfsc_pkg::A_CTRL) fm_en <= d[lcfsc_pkg::CTRL_FM_BIT];
         if (a == lcfsc_pkg::A_RANGE) cap_range <= d[15:0];
         if (a == lcfsc_pkg::A_MASK) mask <= d[SW-1:0];
         if (hit_delay) delay[d_ax] <= d[6:0];
      end
   end

   // offsets and peaks, direct and sequential
   always_ff @(posedge CLK) begin
      if (RST) begin
         ofs_ptr <= 4'h0;
         peak_ptr <= 5'h00;
         peak_seen <= 1'b0;
         for (int i = 0; i < lcfsc_pkg::OFS_SLOTS; i++)
            ofs[i] <= lcfsc_pkg::VAL_RST;
         for (int i = 0; i < lcfsc_pkg::PEAK_SLOTS; i++)
            peak[i] <= lcfsc_pkg::VAL_RST;
      end else if (wr && !rej && !rej_syn) begin
         if (hit_ofs) ofs[o_slot] <= d[12:0];
         if (hit_peak) peak[p_slot] <= d[12:0];
         // start slot 0 for all axes, 2 per axis otherwise
         if (a == lcfsc_pkg::A_OFS_PTR) ofs_ptr <= d[3:0];
         if (a == lcfsc_pkg::A_OFS_SEQ) begin
            ofs[ofs_ptr[2:0]] <= d[12:0];
            ofs_ptr <= ofs_ptr + 4'h1;
         end
         // axis start is four slots per axis
         if (a == lcfsc_pkg::A_PEAK_PTR) begin
            peak_ptr <= {1'b0, d[3:0]};
            peak_seen <= 1'b0;
         end
         if (a == lcfsc_pkg::A_PEAK_SEQ) begin
            peak[peak_ptr[3:0]] <= d[12:0];
            peak_ptr <= peak_ptr + 5'h01;
            peak_seen <= 1'b1;
         end
      end
   end

   // calibration values out to the sensor path
   always_comb begin
      for (int ax = 0; ax < NA; ax++) begin
         MR_OFFSET[ax].sin = ofs[2 * ax];
         MR_OFFSET[ax].cos = ofs[2 * ax + 1];
         for (int k = 0; k < 4; k++) MR_PEAK[ax][k] = peak[4 * ax + k];
      end
   end

   // ==========================================================
   // fast-move restarts
   always_comb begin
      for (int ax = 0; ax < NA; ax++) begin
         exceed[ax] = mag(POS_ERR[ax]) > cap_range;
      end
      // a fresh excursion starts a vector
      restart = exceed & ~exceed_q & {NA{fm_en}};
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         exceed_q <= 4'h0;
         VECTOR_START <= 4'h0;
      end else begin
         exceed_q <= exceed;
         VECTOR_START <= restart;
      end
   end

   // restart counter; a restart in the clearing cycle still counts
   always_comb begin
      if (wr && !rej && a == lcfsc_pkg::A_FMCNT) begin
         cnt_sum = 9'(ones(restart));
      end else begin
         cnt_sum = {1'b0, fm_cnt} + 9'(ones(restart));
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         fm_cnt <= 8'h00;
      end else begin
         fm_cnt <= cnt_sum[8] ? lcfsc_pkg::CNT_MAX : cnt_sum[7:0];
      end
   end

   // ==========================================================
   // controller delay: a shared millisecond tick paces all axes
   always_ff @(posedge CLK) begin
      if (RST) begin
         ms_div <= 0;
         ms_tick <= 1'b0;
      end else begin
         ms_tick <= (ms_div == MS_CYCLES - 1);
         ms_div <= (ms_div == MS_CYCLES - 1) ? 0 : ms_div + 1;
      end
   end

   // requests during a wait are dropped, not queued
   always_ff @(posedge CLK) begin
      if (RST) begin
         CTRL_GO <= 4'h0;
         for (int ax = 0; ax < NA; ax++) begin
            dly_st[ax] <= lcfsc_pkg::DLY_IDLE;
            rem[ax] <= 7'h00;
         end
      end else begin
         for (int ax = 0; ax < NA; ax++) begin
            CTRL_GO[ax] <= 1'b0;
            case (dly_st[ax])
               lcfsc_pkg::DLY_IDLE: begin
                  if (CTRL_REQ[ax]) begin
                     if (delay[ax] == 7'h00) begin
                        CTRL_GO[ax] <= 1'b1;
                     end else begin
                        rem[ax] <= delay[ax];
                        dly_st[ax] <= lcfsc_pkg::DLY_WAIT;
                     end
                  end
               end
               lcfsc_pkg::DLY_WAIT: begin
                  if (ms_tick) begin
                     if (rem[ax] == 7'h01) begin
                        CTRL_GO[ax] <= 1'b1;
                        dly_st[ax] <= lcfsc_pkg::DLY_IDLE;
                     end
                     rem[ax] <= rem[ax] - 7'h01;
                  end
               end
               default: dly_st[ax] <= lcfsc_pkg::DLY_IDLE;
            endcase
         end
      end
   end

   // ==========================================================
   // status, error code and interrupt; set wins over clear
   always_ff @(posedge CLK) begin
      if (RST) begin
         stat <= '0;
         err_code <= 8'h00;
      end else begin
         if (wr && a == lcfsc_pkg::A_STAT) stat <= stat & ~d[SW-1:0];
         if (|restart) stat[lcfsc_pkg::ST_RESTART] <= 1'b1;
         if (rej || rej_syn) stat[lcfsc_pkg::ST_REJECT] <= 1'b1;
         if (cnt_sum[8]) stat[lcfsc_pkg::ST_SAT] <= 1'b1;
         if (wr && a == lcfsc_pkg::A_ERR) err_code <= 8'h00;
         // syntax code 2 outranks a range code
         if (rej_syn) err_code <= lcfsc_pkg::ERR_SYNTAX;
         else if (rej) err_code <= lcfsc_pkg::ERR_RANGE;
      end
   end

   assign IRQ = |(stat & mask);

   // ==========================================================
   // live sample store
   lcfsc_sample #(
      .DEPTH(lcfsc_pkg::LIVE_DEPTH),
      .N(NA)
   ) u_sample (
      .CLK(CLK),
      .RST(RST),
      .SAMPLE_VALID(MR_VALID),
      .SAMPLE(MR_SAMPLE),
      .RD_STROBE(live_rd),
      .RD_AXIS(a[7:6]),
      .RD_IDX(a[5:2]),
      .RD_PAIR(live_pair)
   );
endmodule
`default_nettype wire

/* File: lcfsc_sample.sv */
/*
 * Shared constants, field layout and carrier type of the loop delay,
 * fast-move and sensor calibration block, and the live sample store
 * that keeps the newest sine/cosine pairs of every axis.
 * Assumes sensor samples arrive already digitised on the block clock,
 * qualified by one valid strobe for all axes together.
 */
`timescale 1ns/1ns
`default_nettype none
package lcfsc_pkg;
   // ==========================================================
   // sizes and limits
   localparam int N_AXES = 4;
   localparam int VAL_W = 13;
   localparam int LIVE_DEPTH = 10;
   localparam int OFS_SLOTS = 8;
   localparam int PEAK_SLOTS = 16;
   localparam logic [6:0] DELAY_MAX = 7'h64;
   localparam logic [7:0] CNT_MAX = 8'hff;
   localparam logic signed [31:0] VAL_LIM = 32'sh00000800;
   localparam logic [7:0] ERR_SYNTAX = 8'h02;
   localparam logic [7:0] ERR_RANGE = 8'h03;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   // ==========================================================
   // register byte offsets
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_STAT = 12'h004;
   localparam logic [11:0] A_MASK = 12'h008;
   localparam logic [11:0] A_ERR = 12'h00c;
   localparam logic [11:0] A_DELAY_ALL = 12'h010;
   localparam logic [11:0] A_FMCNT = 12'h014;
   localparam logic [11:0] A_RANGE = 12'h018;
   localparam logic [11:0] A_OFS_PTR = 12'h01c;
   localparam logic [11:0] A_OFS_SEQ = 12'h020;
   localparam logic [11:0] A_PEAK_PTR = 12'h024;
   localparam logic [11:0] A_PEAK_SEQ = 12'h028;
   localparam logic [11:0] A_LIVE_ALL = 12'h02c;
   localparam logic [11:0] A_DELAY_BASE = 12'h030;
   localparam logic [11:0] A_OFS_BASE = 12'h040;
   localparam logic [11:0] A_PEAK_BASE = 12'h060;
   localparam logic [11:0] A_PEAK_END = 12'h0a0;
   localparam logic [11:0] A_LIVE_BASE = 12'h100;
   localparam logic [11:0] A_LIVE_END = 12'h200;
   // ==========================================================
   // field positions and reset values
   localparam int CTRL_FM_BIT = 0;
   localparam int PEAK_END_BIT = 8;
   localparam int LIVE_COS_LSB = 16;
   localparam int ST_RESTART = 0;
   localparam int ST_REJECT = 1;
   localparam int ST_SAT = 2;
   localparam int STAT_W = 3;
   localparam logic [15:0] RANGE_RST = 16'h0010;
   localparam logic [6:0] DELAY_RST = 7'h00;
   localparam logic [12:0] VAL_RST = 13'h0000;
   // ==========================================================
   // one sine/cosine pair
   typedef struct packed {
      logic signed [12:0] cos;
      logic signed [12:0] sin;
   } lcfsc_pair_s;
   // per-axis delay sequencer states
   typedef enum logic [1:0] {
      DLY_IDLE = 2'b01,
      DLY_WAIT = 2'b10
   } lcfsc_dly_e;
endpackage

// ==========================================================
// live sample ring, oldest first on read
module lcfsc_sample #(
   parameter int DEPTH = lcfsc_pkg::LIVE_DEPTH,
   parameter int N = lcfsc_pkg::N_AXES
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic SAMPLE_VALID,
   input wire lcfsc_pkg::lcfsc_pair_s [N-1:0] SAMPLE,
   input wire logic RD_STROBE,
   input wire logic [1:0] RD_AXIS,
   input wire logic [3:0] RD_IDX,
   output lcfsc_pkg::lcfsc_pair_s RD_PAIR
);
   localparam logic [3:0] LAST = 4'(DEPTH - 1);
   localparam logic [4:0] DEPTH5 = 5'(DEPTH);
   lcfsc_pkg::lcfsc_pair_s mem [N][DEPTH];
   logic [3:0] wp [N];
   logic [N-1:0] frozen;
   logic [4:0] slot;

   // ring fill; a frozen axis keeps its ten pairs coherent while read
   always_ff @(posedge CLK) begin
      if (RST) begin
         for (int ax = 0; ax < N; ax++) begin
            wp[ax] <= 4'h0;
            for (int k = 0; k < DEPTH; k++) begin
               mem[ax][k] <= '0;
            end
         end
      end else if (SAMPLE_VALID) begin
         for (int ax = 0; ax < N; ax++) begin
            if (!frozen[ax]) begin
               mem[ax][wp[ax]] <= SAMPLE[ax];
               wp[ax] <= (wp[ax] == LAST) ? 4'h0 : wp[ax] + 4'h1;
            end
         end
      end
   end

   // freeze on the first pair, release after the last
   always_ff @(posedge CLK) begin
      if (RST) begin
         frozen <= '0;
      end else if (RD_STROBE) begin
         if (RD_IDX == 4'h0) begin
            frozen[RD_AXIS] <= 1'b1;
         end else if (RD_IDX == LAST) begin
            frozen[RD_AXIS] <= 1'b0;
         end
      end
   end

   // write pointer marks the oldest pair
   always_comb begin
      slot = {1'b0, wp[RD_AXIS]} + {1'b0, RD_IDX};
      if (slot >= DEPTH5) begin
         slot = slot - DEPTH5;
      end
      RD_PAIR = mem[RD_AXIS][slot[3:0]];
   end
endmodule
`default_nettype wire

/* File: lcfsc_checker_properties.sv */
/* port checks of lcfsc_top: bus answer, output pulses, held settings.
   assumes one clock CLK with synchronous active-high reset RST. */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// checker
module lcfsc_props #(
   parameter int MS_CYCLES = lcfsc_pkg::MS_CYCLES
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic [3:0][15:0] POS_ERR,
   input wire logic [3:0] CTRL_GO,
   input wire logic [3:0] VECTOR_START,
   input wire lcfsc_pkg::lcfsc_pair_s [3:0] MR_OFFSET
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   // a request the slave has not yet answered
   logic req;
   assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   ack_follows_req_a: assert property (
      req |=> WB_ACK_O) else $error("request not acked next cycle");
   ack_single_a: assert property (
      WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
   ack_cause_a: assert property (
      $rose(WB_ACK_O) |-> $past(req)) else $error("ack without request");
   read_idle_a: assert property (
      !WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data outside ack");
   go_pulse_a: assert property (
      CTRL_GO[0] |=> !CTRL_GO[0]) else $error("go longer than a pulse");
   vector_pulse_a: assert property (
      VECTOR_START[0] |=> !VECTOR_START[0]) else $error("vector stuck");
   vector_cause_a: assert property (
      VECTOR_START[0] |-> $past(POS_ERR[0]) != 16'h0)
      else $error("vector without error");
   // offsets move only at a taken full-word write
   offset_hold_a: assert property (
      !(req && WB_WE_I && WB_SEL_I == 4'hf) |=> $stable(MR_OFFSET))
      else $error("offset changed without write");
endmodule
bind lcfsc_top lcfsc_props #(.MS_CYCLES(MS_CYCLES)) u_lcfsc_props (
   .CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .POS_ERR(POS_ERR), .CTRL_GO(CTRL_GO),
   .VECTOR_START(VECTOR_START), .MR_OFFSET(MR_OFFSET));
`default_nettype wire

/* File: lcfsc_host.sv */
/* host model: classic single-cycle bus master issuing settings.
   assumes the caller enters xfer right after a rising edge. */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// bus master
module lcfsc_host (
   input wire logic clk,
   input wire logic ack,
   input wire logic [31:0] dat_i,
   output var logic cyc,
   output var logic stb,
   output var logic we,
   output var logic [11:0] adr,
   output var logic [3:0] sel,
   output var logic [31:0] dat
);
   // idle bus from time zero
   initial begin
      {cyc, stb, we, adr, sel, dat} = '0;
   end
   // hold the request until ack is sampled; a dead slave is caught
   // by the bench watchdog, not here
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hf, d};
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = dat_i;
      {cyc, stb} <= 2'b00;
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

/* File: tb_lcfsc_top.sv */
/* self-checking bench of lcfsc_top.
   assumes lcfsc_pkg, the host model and the checker compile first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin \
   miscompares++; \
   $display("mismatch %s exp %h got %h", nm, e, s); end end
// ==========================================================
// bench top
module tb_lcfsc_top;
   localparam int MS = 20;
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } lcfsc_row_s;
   logic clk = 1'b0, rst = 1'b1, mr_valid = 1'b0;
   logic cyc, stb, we, ack, irq;
   logic [11:0] adr;
   logic [3:0] sel, go, vs;
   logic [3:0] req = '0;
   logic [31:0] dat, rdat, q;
   logic [3:0][15:0] pos_err = '0;
   lcfsc_pkg::lcfsc_pair_s [3:0] samp = '0;
   lcfsc_pkg::lcfsc_pair_s [3:0] ofs;
   logic [3:0][3:0][12:0] peak;
   int miscompares = 0, checked = 0, n, vc;
   // write, read back: ctrl, delays, offsets, peaks, unmapped
   lcfsc_row_s rows [9] = '{'{12'h000, 32'h1, 32'h1},
      '{12'h000, 32'h0, 32'h0}, '{12'h030, 32'h64, 32'h64},
      '{12'h034, 32'h2, 32'h2}, '{12'h040, 32'h14, 32'h14},
      '{12'h044, 32'hfffffffd, 32'hfffffffd},
      '{12'h060, 32'hfffff800, 32'hfffff800},
      '{12'h064, 32'h800, 32'h800}, '{12'h0f0, 32'h5, 32'h0}};
   always #(lcfsc_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
   lcfsc_host u_lcfsc_host (.clk(clk), .ack(ack), .dat_i(rdat),
      .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(dat));
   // short ms so delay waits stay cheap
   lcfsc_top #(.MS_CYCLES(MS)) u_lcfsc_top (.CLK(clk), .RST(rst),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .POS_ERR(pos_err), .CTRL_REQ(req), .CTRL_GO(go),
      .VECTOR_START(vs), .MR_VALID(mr_valid), .MR_SAMPLE(samp),
      .MR_OFFSET(ofs), .MR_PEAK(peak), .IRQ(irq));
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      u_lcfsc_host.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      u_lcfsc_host.xfer(1'b0, a, 32'h0, q);
      `CHK($sformatf("rd %h", a), e, q)
   endtask
   // k rising position errors of -17 on axis x, counting vectors
   task automatic bump(input int k);
      vc = 0;
      repeat (k) begin
         pos_err[0] <= 16'hffef;
         @(posedge clk);
         vc += int'(vs[0]);
         pos_err[0] <= 16'h0000;
         @(posedge clk);
         vc += int'(vs[0]);
      end
      @(posedge clk);
      vc += int'(vs[0]);
   endtask
   task automatic finish_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // watchdog, well beyond the roughly 800 cycles of the run
   initial begin
      repeat (8000) @(posedge clk);
      miscompares++;
      finish_test();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      $display("test table done");
      // mid-run reset must clear what the table wrote
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(12'h030, 32'h0);
      rd(12'h014, 32'h0);
      rd(12'h018, {16'h0, lcfsc_pkg::RANGE_RST});
      $display("test reset done");
      wr(12'h030, 32'h64);
      wr(12'h034, 32'h2);
      rd(12'h010, 32'h00000264);
      wr(12'h038, 32'h65);
      rd(12'h038, 32'h0);
      rd(12'h00c, {24'h0, lcfsc_pkg::ERR_RANGE});
      rd(12'h004, 32'h2);
      `CHK("irq masked", 1'b0, irq)
      wr(12'h008, 32'h2);
      `CHK("irq", 1'b1, irq)
      wr(12'h004, 32'h2);
      `CHK("irq cleared", 1'b0, irq)
      $display("test delay regs done");
      wr(12'h030, 32'h0);
      req <= 4'b0011;
      @(posedge clk);
      req <= 4'b0000;
      @(posedge clk);
      `CHK("go x", 1'b1, go[0])
      n = 1;
      while (go[1] !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      `CHK("go y wait", 1'b1, n >= MS + 1 && n <= 2 * MS + 2)
      $display("test delay done");
      wr(12'h000, 32'h1);
      bump(1);
      `CHK("vectors", 1, vc)
      rd(12'h014, 32'h1);
      wr(12'h014, 32'h0);
      rd(12'h014, 32'h0);
      bump(2);
      rd(12'h014, 32'h2);
      bump(260);
      rd(12'h014, {24'h0, lcfsc_pkg::CNT_MAX});
      wr(12'h000, 32'h0);
      bump(1);
      `CHK("vectors off", 0, vc)
      wr(12'h000, 32'h2);
      rd(12'h000, 32'h0);
      $display("test fast move done");
      wr(12'h01c, 32'h0);
      wr(12'h020, 32'h14);
      wr(12'h020, 32'hfffffffd);
      wr(12'h020, 32'h38);
      rd(12'h044, 32'hfffffffd);
      rd(12'h04c, 32'h0);
      `CHK("ofs y sin", 13'h0038, ofs[1].sin)
      wr(12'h024, 32'h100);
      rd(12'h00c, 32'h2);
      wr(12'h024, 32'h4);
      wr(12'h028, 32'h3e8);
      wr(12'h028, 32'hfffffc18);
      wr(12'h028, 32'h3e8);
      `CHK("peak y", {13'h0, 13'h3e8, 13'h1c18, 13'h3e8}, peak[1])
      $display("test calibration done");
      for (int k = 0; k < 10; k++) begin
         mr_valid <= 1'b1;
         samp[2] <= {13'(-k), 13'(k + 1)};
         @(posedge clk);
      end
      mr_valid <= 1'b0;
      @(posedge clk);
      for (int k = 0; k < 10; k++) begin
         u_lcfsc_host.xfer(1'b0, 12'h180 + 12'(4 * k), 32'h0, q);
         `CHK("live", {13'(-k), 13'(k + 1)}, {q[28:16], q[12:0]})
      end
      wr(12'h00c, 32'h0);
      rd(12'h00c, 32'h0);
      rd(12'h02c, 32'h0);
      rd(12'h00c, 32'h2);
      wr(12'h00c, 32'h0);
      wr(12'h02c, 32'h0);
      rd(12'h00c, 32'h2);
      $display("test live done");
      finish_test();
   end
endmodule
`default_nettype wire
